/* rtl/dma_channel_status_irq_bank.sv */
// DMA channel status and interrupt register bank, 16 channels.
// Assumes engine events arrive on clk_i from the transfer engine and
// software uses a one-cycle strobe register port, read data next cycle.
`timescale 1ns/1ps
`default_nettype none

module dma_channel_status_irq_bank (
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  input  wire dma_stat_pkg::reg_req_s        req_i,
  output logic      [dma_stat_pkg::DATA_W-1:0] rdata_o,
  input  wire dma_stat_pkg::engine_evt_s     evt_i,
  output logic                               irq_o
);
  import dma_stat_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // Helpers
  ////////////////////////////////////////////////////////////////////

  // Write strobe for one register, masked to channel bits
  function automatic chan_vec_t wr_ones(input reg_req_s r,
                                        input logic [ADDR_W-1:0] a);
    if (r.wr && r.addr == a) begin
      return r.wdata[NUM_CH-1:0];
    end
    return '0;
  endfunction

  // Place a channel vector in a bus word, upper bits zero
  function automatic logic [DATA_W-1:0] widen(input chan_vec_t v);
    return {{(DATA_W-NUM_CH){1'b0}}, v};
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Registers
  ////////////////////////////////////////////////////////////////////

  chan_vec_t running_reg;
  chan_vec_t occupied_reg;
  chan_vec_t irq_allow_reg;
  chan_vec_t fault_flags;
  chan_vec_t comp_a_flags;
  chan_vec_t comp_b_flags;
  chan_vec_t comp_a_set;
  chan_vec_t comp_b_set;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic              irq_reg;
  logic              irq_next;

  // Running flags follow start and drain; start wins over drain
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      running_reg <= FLAGS_RST;
    end else begin
      running_reg <= (running_reg & ~evt_i.drained)
                     | evt_i.start;
    end
  end

  // Occupied view, kept regardless of channel enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      occupied_reg <= FLAGS_RST;
    end else begin
      occupied_reg <= evt_i.in_pipe;
    end
  end

  // Interrupt enables: set by ones, cleared by ones on clear register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_allow_reg <= FLAGS_RST;
    end else begin
      irq_allow_reg <= (irq_allow_reg
                        & ~wr_ones(req_i, ADDR_IEN_CLR))
                       | wr_ones(req_i, ADDR_IEN_SET);
    end
  end

  // Completion events only from exhaust; faults never feed them
  assign comp_a_set = evt_i.exhaust & evt_i.raise_a;
  assign comp_b_set = evt_i.exhaust & evt_i.raise_b;

  // Fault flags, set wins over clear
  w1c_flag_set u_fault (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .set_i   (evt_i.fault),
    .clr_i   (wr_ones(req_i, ADDR_FAULT)),
    .flags_o (fault_flags)
  );

  // Completion-A flags
  w1c_flag_set u_comp_a (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .set_i   (comp_a_set),
    .clr_i   (wr_ones(req_i, ADDR_COMP_A)),
    .flags_o (comp_a_flags)
  );

  // Completion-B flags
  w1c_flag_set u_comp_b (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .set_i   (comp_b_set),
    .clr_i   (wr_ones(req_i, ADDR_COMP_B)),
    .flags_o (comp_b_flags)
  );

  ////////////////////////////////////////////////////////////////////
  // Read path
  ////////////////////////////////////////////////////////////////////

  // Read mux; write-only and unmapped addresses read zero
  always_comb begin
    rdata_next = RDATA_RST;
    if (req_i.rd) begin
      case (req_i.addr)
        ADDR_RUNNING:  rdata_next = widen(running_reg);
        ADDR_OCCUPIED: rdata_next = widen(occupied_reg);
        ADDR_FAULT:    rdata_next = widen(fault_flags);
        ADDR_IEN_SET:  rdata_next = widen(irq_allow_reg);
        ADDR_COMP_A:   rdata_next = widen(comp_a_flags);
        ADDR_COMP_B:   rdata_next = widen(comp_b_flags);
        default:       rdata_next = RDATA_RST;
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_reg <= RDATA_RST;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata_o = rdata_reg;

  ////////////////////////////////////////////////////////////////////
  // Interrupt output
  ////////////////////////////////////////////////////////////////////

  // Faults unmasked, completions gated by the channel enable
  assign irq_next = (|fault_flags)
                  | (|(comp_a_flags & irq_allow_reg))
                  | (|(comp_b_flags & irq_allow_reg));

  // Registered interrupt line
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  assign irq_o = irq_reg;

endmodule // dma_channel_status_irq_bank

`default_nettype wire

/* rtl/dma_stat_pkg.sv */
// Package: register map, widths and event carriers for the DMA
// channel status and interrupt bank.
// Assumes a plain address/strobe register port with 32-bit data.
`default_nettype none

package dma_stat_pkg;

  localparam int unsigned NUM_CH    = 16;
  localparam int unsigned ADDR_W    = 32;
  localparam int unsigned DATA_W    = 32;

  // Byte addresses of the bank's registers
  localparam logic [ADDR_W-1:0] ADDR_RUNNING   = 32'h5000_4030;
  localparam logic [ADDR_W-1:0] ADDR_OCCUPIED  = 32'h5000_4038;
  localparam logic [ADDR_W-1:0] ADDR_FAULT     = 32'h5000_4040;
  localparam logic [ADDR_W-1:0] ADDR_IEN_SET   = 32'h5000_4048;
  localparam logic [ADDR_W-1:0] ADDR_IEN_CLR   = 32'h5000_4050;
  localparam logic [ADDR_W-1:0] ADDR_COMP_A    = 32'h5000_4058;
  localparam logic [ADDR_W-1:0] ADDR_COMP_B    = 32'h5000_4060;

  // Reset values of the readable flag sets
  localparam logic [NUM_CH-1:0] FLAGS_RST      = 16'h0000;
  localparam logic [DATA_W-1:0] RDATA_RST      = 32'h0000_0000;

  typedef logic [NUM_CH-1:0] chan_vec_t;

  // Per-channel events reported by the transfer engine
  typedef struct packed {
    chan_vec_t start;      // Transfer operation starts
    chan_vec_t drained;    // Pipeline empty after last descriptor
    chan_vec_t in_pipe;    // Any operation still in the pipeline
    chan_vec_t fault;      // Channel fault detected
    chan_vec_t exhaust;    // Descriptor exhausted
    chan_vec_t raise_a;    // raise_a_on_exhaust of current config
    chan_vec_t raise_b;    // raise_b_on_exhaust of current config
  } engine_evt_s;

  // Register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_s;

endpackage : dma_stat_pkg

`default_nettype wire

/* rtl/w1c_flag_set.sv */
// W1C flag vector with set-over-clear priority.
// Assumes set and clear are one-cycle pulses on clk_i.
`timescale 1ns/1ps
`default_nettype none

module w1c_flag_set (
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  input  wire logic [dma_stat_pkg::NUM_CH-1:0] set_i,
  input  wire logic [dma_stat_pkg::NUM_CH-1:0] clr_i,
  output logic      [dma_stat_pkg::NUM_CH-1:0] flags_o
);
  import dma_stat_pkg::*;

  chan_vec_t flags_reg;

  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_reg <= FLAGS_RST;
    end else begin
      flags_reg <= (flags_reg & ~clr_i) | set_i;
    end
  end

  assign flags_o = flags_reg;

endmodule // w1c_flag_set

`default_nettype wire

/* sim/dma_bank_monitor.sv */
// Checker: port-level timing of the status and interrupt bank.
// Assumes it is bound onto the bank's top module, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module dma_bank_monitor (
  input wire logic                            clk_i,
  input wire logic                            rst_i,
  input wire dma_stat_pkg::reg_req_s          req_i,
  input wire logic [dma_stat_pkg::DATA_W-1:0] rdata_o,
  input wire dma_stat_pkg::engine_evt_s       evt_i,
  input wire logic                            irq_o
);
  import dma_stat_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////
  a_rdata_idle: assert property (!$past(req_i.rd) |-> rdata_o == '0)
    else $error("read data outside its slot");
  a_upper_zero: assert property (rdata_o[31:16] == 16'h0000)
    else $error("reserved bits not zero");
  a_fault_irq: assert property (|evt_i.fault |-> ##2 irq_o)
    else $error("fault did not raise irq");
  a_occ_view: assert property (
    req_i.rd && req_i.addr == ADDR_OCCUPIED |=>
    rdata_o == {16'h0000, $past(evt_i.in_pipe, 2)})
    else $error("occupied view wrong");
  a_run_view: assert property (
    req_i.rd && req_i.addr == ADDR_RUNNING |=>
    (rdata_o[15:0] & $past(evt_i.start, 2)) == $past(evt_i.start, 2))
    else $error("running flag missing after start");
  a_clr_rd_zero: assert property (
    req_i.rd && req_i.addr == ADDR_IEN_CLR |=> rdata_o == '0)
    else $error("enable clear readable");
  a_irq_cause: assert property ($rose(irq_o) |->
    $past(|evt_i.fault || |evt_i.exhaust || req_i.wr, 2))
    else $error("irq rose without cause");
  a_irq_drop: assert property ($fell(irq_o) |-> $past(req_i.wr, 2))
    else $error("irq fell without write");
  // Main scenarios reached
  c_irq_up: cover property ($rose(irq_o));
  c_fault_rd: cover property (req_i.rd && req_i.addr == ADDR_FAULT);
  c_comp_b: cover property (|(evt_i.exhaust & evt_i.raise_b));
endmodule // dma_bank_monitor
bind dma_channel_status_irq_bank dma_bank_monitor mon_u (.clk_i(clk_i),
  .rst_i(rst_i), .req_i(req_i), .rdata_o(rdata_o), .evt_i(evt_i),
  .irq_o(irq_o));
`default_nettype wire

/* sim/dma_channel_status_irq_bank_tb_top.sv */
// Testbench: drives register port and engine events, checks reads/irq.
// Assumes package, bank and bound monitor are compiled first.
`timescale 1ns/1ps
`default_nettype none
module dma_channel_status_irq_bank_tb_top;
  import dma_stat_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  reg_req_s    req = '0;
  engine_evt_s evt = '0;
  logic [31:0] rdata;
  logic        irq;
  int          bad_count = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  dma_channel_status_irq_bank dut_u (.clk_i(clk_i), .rst_i(rst_i),
    .req_i(req), .rdata_o(rdata), .evt_i(evt), .irq_o(irq));
  // Clock and hang guard
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      bad_count++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [31:0] a, d);
    @(posedge clk_i);
    req <= {a, d, 2'b10};
    @(posedge clk_i);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, e, input string n);
    @(posedge clk_i);
    req <= {a, 32'h0000_0000, 2'b01};
    @(posedge clk_i);
    req.rd <= 1'b0;
    #1 chk(n, e, rdata);
  endtask
  // One-cycle event pulse; pipeline level kept afterwards
  task automatic ev(input engine_evt_s v);
    engine_evt_s h;
    h = '0;
    h.in_pipe = v.in_pipe;
    @(posedge clk_i);
    evt <= v;
    @(posedge clk_i);
    evt <= h;
  endtask
  task automatic irq_is(input logic e, input string n);
    repeat (2) @(posedge clk_i);
    #1 chk(n, {31'h0, e}, {31'h0, irq});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_status();
    engine_evt_s h;
    h = '0;
    h.start = 16'h8001;
    h.in_pipe = 16'h8001;
    ev(h);
    wr(ADDR_RUNNING, 32'hFFFF_FFFF);
    rd(ADDR_RUNNING, 32'h0000_8001, "running");
    rd(ADDR_OCCUPIED, 32'h0000_8001, "occupied");
    h = '0;
    h.drained = 16'h8001;
    h.in_pipe = 16'h8000;
    ev(h); // abort seen only as drained
    rd(ADDR_RUNNING, 32'h0000_0000, "drained");
    rd(ADDR_OCCUPIED, 32'h0000_8000, "occupied kept");
    ev('0);
  endtask
  task automatic t_fault();
    engine_evt_s h;
    h = '0;
    h.fault = 16'h8001;
    ev(h);
    irq_is(1'b1, "fault irq");
    rd(ADDR_FAULT, 32'h0000_8001, "fault");
    rd(ADDR_COMP_A, 32'h0000_0000, "no comp");
    wr(ADDR_FAULT, 32'hFFFF_0001);
    rd(ADDR_FAULT, 32'h0000_8000, "fault w1c");
    wr(ADDR_FAULT, 32'h0000_8000);
    irq_is(1'b0, "fault irq off");
  endtask
  task automatic t_comp(input bit b);
    engine_evt_s h;
    logic [31:0] fa;
    fa = b ? ADDR_COMP_B : ADDR_COMP_A;
    h = '0;
    h.exhaust = 16'h0024;
    h.raise_a = b ? 16'h0000 : 16'h0024;
    h.raise_b = b ? 16'h0024 : 16'h0000;
    ev(h);
    irq_is(1'b0, "masked");
    rd(fa, 32'h0000_0024, "comp set");
    rd(fa ^ 32'h0000_0038, 32'h0000_0000, "other comp");
    rd(ADDR_FAULT, 32'h0000_0000, "no fault");
    wr(ADDR_IEN_SET, 32'hFFFF_0020);
    rd(ADDR_IEN_SET, 32'h0000_0020, "enable");
    wr(ADDR_IEN_CLR, 32'h0000_0000);
    wr(ADDR_IEN_SET, 32'h0000_0000);
    rd(ADDR_IEN_SET, 32'h0000_0020, "enable zeros");
    irq_is(1'b1, "unmasked");
    wr(ADDR_IEN_CLR, 32'h0000_0020);
    irq_is(1'b0, "enable clr");
    wr(fa, 32'h0000_0004);
    rd(fa, 32'h0000_0020, "comp w1c");
    wr(fa, 32'h0000_0020);
  endtask
  task automatic t_race();
    @(posedge clk_i);
    req <= {ADDR_FAULT, 32'h0000_0002, 2'b10};
    evt.fault <= 16'h0002;
    @(posedge clk_i);
    req.wr <= 1'b0;
    evt.fault <= 16'h0000;
    rd(ADDR_FAULT, 32'h0000_0002, "set wins");
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(ADDR_IEN_SET, 32'h0000_0000, "enable reset");
    rd(32'h5000_4034, 32'h0000_0000, "unmapped");
    t_status();
    t_fault();
    t_comp(1'b0);
    t_comp(1'b1);
    t_race();
    summarize();
  end
endmodule // dma_channel_status_irq_bank_tb_top
`default_nettype wire
